// ---- dcs_pkg.sv ----
package dcs_pkg;
	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_INT_FLAGS = 8'h14;
	localparam logic [7:0] ADDR_INT_ENABLES = 8'h18;

	// ---------------------------------------------------------------
	// Control register fields
	// ---------------------------------------------------------------
	localparam int CTL_RUN_BIT = 0;
	localparam int CTL_REQUEST_BIT = 1;
	localparam int CTL_DONE_BIT = 2;
	localparam int CTL_STATUS_LSB = 3;
	localparam int CTL_BUSY_BIT = 5;
	localparam int CTL_DIR_BIT = 8;
	localparam int CTL_INC_MEM_BIT = 16;
	localparam int CTL_DISABLE_HWFC_BIT = 19;

	// ---------------------------------------------------------------
	// Interrupt flag and enable fields
	// ---------------------------------------------------------------
	localparam int INT_BUS_ERR_BIT = 0;
	localparam int INT_FLOW_BIT = 1;
	localparam int INT_DONE_BIT = 2;
	localparam int INT_WIDTH = 3;
	localparam logic [2:0] INT_RESET = 3'h0;
	localparam logic [2:0] ENA_RESET = 3'h0;

	// ---------------------------------------------------------------
	// Status encodings
	// ---------------------------------------------------------------
	localparam logic [1:0] STAT_RUN_OFF = 2'h0;
	localparam logic [1:0] STAT_LIMIT = 2'h1;
	localparam logic [1:0] STAT_TERM = 2'h2;
	localparam logic [1:0] STAT_ERROR = 2'h3;

	// Channel states
	typedef enum logic [1:0] {
		DCS_IDLE,
		DCS_XFER,
		DCS_DONE
	} dcs_state_e;
endpackage

// ---- dcs_sync.sv ----
`timescale 1ns/1ps
// -------------------------------------------------------------------
// Two-stage synchroniser for an input from outside the clock domain
// -------------------------------------------------------------------
module dcs_sync (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_ff <= 1'b0;
			o_sync <= 1'b0;
		end else begin
			meta_ff <= i_async;
			o_sync <= meta_ff;
		end
	end
endmodule // dcs_sync

// ---- dcs_channel.sv ----
`timescale 1ns/1ps
module dcs_channel #(
	parameter int ADDR_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	// Register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Hardware flow-control pins from the master device
	input wire logic i_fc_req,
	input wire logic i_fc_term,
	// Status from the address datapath and internal bus
	input wire logic i_addr_limit,
	input wire logic i_bus_error,
	input wire logic i_pkt_done,
	// Flow-control answers and channel outputs
	output logic o_fc_done,
	output logic o_pkt_start,
	output logic o_busy,
	output logic o_irq
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	dcs_pkg::dcs_state_e state_ff;
	dcs_pkg::dcs_state_e nxt_state;
	logic req_s;
	logic term_s;
	logic run_ff;
	logic dir_ff;
	logic inc_mem_ff;
	logic hwfc_off_ff;
	logic done_ff;
	logic term_seen_ff;
	logic limit_seen_ff;
	logic err_seen_ff;
	logic [dcs_pkg::INT_WIDTH-1:0] flags_ff;
	logic [dcs_pkg::INT_WIDTH-1:0] ena_ff;
	logic [dcs_pkg::INT_WIDTH-1:0] flag_set;
	logic [dcs_pkg::INT_WIDTH-1:0] flag_clr;
	logic [1:0] status;
	logic req_live;
	logic term_live;
	logic wr_ctl;
	logic wr_flags;
	logic wr_ena;
	logic [31:0] ctl_word;
	logic [31:0] nxt_rdata;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Master pins come from outside this clock domain
	// Two flops each, so two cycles of latency on both pins
	// Limitation: a request dropped just before completion is still
	// seen for two cycles and can count as overflow in done
	dcs_sync u_sync_req (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async(i_fc_req),
		.o_sync(req_s)
	);

	dcs_sync u_sync_term (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async(i_fc_term),
		.o_sync(term_s)
	);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	// Write strobes per register; reads decode in the read path
	// Unmapped writes match nothing and change nothing
	assign wr_ctl = i_wr && (i_addr == ADDR_W'(dcs_pkg::ADDR_CONTROL));
	assign wr_flags = i_wr && (i_addr == ADDR_W'(dcs_pkg::ADDR_INT_FLAGS));
	assign wr_ena = i_wr && (i_addr == ADDR_W'(dcs_pkg::ADDR_INT_ENABLES));

	// Pins are dropped when hardware flow control is switched off
	assign req_live = req_s && !hwfc_off_ff;
	assign term_live = term_s && !hwfc_off_ff;

	// ---------------------------------------------------------------
	// Control register, software-written fields
	// ---------------------------------------------------------------
	// Request, done, status and busy are not stored here
	// Whole word written at once, so each write sets every field
	// Run bit is only meaningful with hardware flow control
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_ff <= 1'b0;
			dir_ff <= 1'b0;
			inc_mem_ff <= 1'b0;
			hwfc_off_ff <= 1'b0;
		end else if (wr_ctl) begin
			run_ff <= i_wdata[dcs_pkg::CTL_RUN_BIT];
			dir_ff <= i_wdata[dcs_pkg::CTL_DIR_BIT];
			inc_mem_ff <= i_wdata[dcs_pkg::CTL_INC_MEM_BIT];
			hwfc_off_ff <= i_wdata[dcs_pkg::CTL_DISABLE_HWFC_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Channel state machine
	// ---------------------------------------------------------------
	// Idle: waits for a synced request while running
	// Xfer: one packet in flight in the datapath
	// Done: transfer over, held until firmware clears run
	// Run dropping mid-packet does not abort; the packet completes
	// Error and terminate win over the address limit
	// Packet end below the limit returns to idle for the next one
	// Requests start a packet only while running
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			dcs_pkg::DCS_IDLE: begin
				if (run_ff && req_live) begin
					nxt_state = dcs_pkg::DCS_XFER;
				end
			end
			dcs_pkg::DCS_XFER: begin
				if (i_bus_error || term_live) begin
					nxt_state = dcs_pkg::DCS_DONE;
				end else if (i_pkt_done && i_addr_limit) begin
					nxt_state = dcs_pkg::DCS_DONE;
				end else if (i_pkt_done) begin
					nxt_state = dcs_pkg::DCS_IDLE;
				end
			end
			dcs_pkg::DCS_DONE: begin
				// Stays done until firmware stops the channel
				if (!run_ff) begin
					nxt_state = dcs_pkg::DCS_IDLE;
				end
			end
			default: begin
				nxt_state = dcs_pkg::DCS_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_ff <= dcs_pkg::DCS_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// One pulse per packet launched to the datapath
	// Same condition as the idle-to-transfer step above
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pkt_start <= 1'b0;
		end else begin
			o_pkt_start <= (state_ff == dcs_pkg::DCS_IDLE) && run_ff &&
				req_live;
		end
	end

	// ---------------------------------------------------------------
	// Completion causes, kept until the channel leaves done
	// ---------------------------------------------------------------
	// Several causes may hold at once; all of them are kept
	// The status field then picks one of them by priority
	// All cleared together when the channel goes back to idle
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done_ff <= 1'b0;
			term_seen_ff <= 1'b0;
			limit_seen_ff <= 1'b0;
			err_seen_ff <= 1'b0;
		end else if (nxt_state == dcs_pkg::DCS_IDLE &&
			state_ff == dcs_pkg::DCS_DONE) begin
			done_ff <= 1'b0;
			term_seen_ff <= 1'b0;
			limit_seen_ff <= 1'b0;
			err_seen_ff <= 1'b0;
		end else if (state_ff == dcs_pkg::DCS_XFER &&
			nxt_state == dcs_pkg::DCS_DONE) begin
			done_ff <= 1'b1;
			term_seen_ff <= term_live;
			limit_seen_ff <= i_pkt_done && i_addr_limit;
			err_seen_ff <= i_bus_error;
		end
	end

	// Done answer to the master device, held while done
	// Master is expected to drop its request on seeing it
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fc_done <= 1'b0;
		end else begin
			o_fc_done <= (nxt_state == dcs_pkg::DCS_DONE);
		end
	end

	// ---------------------------------------------------------------
	// Interrupt flags
	// ---------------------------------------------------------------
	// Three sources: limit completion, overflow, bus error
	// Each flag is sticky; firmware clears it by writing 1
	// Bus error is caught in any state, not only in a transfer
	// Completion only on reaching the address limit, never on terminate
	assign flag_set[dcs_pkg::INT_DONE_BIT] =
		state_ff == dcs_pkg::DCS_XFER && i_pkt_done && i_addr_limit &&
		!term_live && !i_bus_error;
	// Master still asking after the transfer completed means overflow
	assign flag_set[dcs_pkg::INT_FLOW_BIT] =
		state_ff == dcs_pkg::DCS_DONE && req_live;
	assign flag_set[dcs_pkg::INT_BUS_ERR_BIT] = i_bus_error;
	assign flag_clr = wr_flags ? i_wdata[dcs_pkg::INT_WIDTH-1:0] :
		{dcs_pkg::INT_WIDTH{1'b0}};

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flags_ff <= dcs_pkg::INT_RESET;
		end else begin
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
		end
	end

	// Enables are plain read-write bits; upper bits ignored
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ena_ff <= dcs_pkg::ENA_RESET;
		end else if (wr_ena) begin
			ena_ff <= i_wdata[dcs_pkg::INT_WIDTH-1:0];
		end
	end

	// Interrupt is the registered OR of enabled flags
	// Registered pin costs one cycle after the flag sets
	// Masking hides a flag here but leaves it readable
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <=
				(flags_ff[dcs_pkg::INT_DONE_BIT] &&
				ena_ff[dcs_pkg::INT_DONE_BIT]) ||
				(flags_ff[dcs_pkg::INT_FLOW_BIT] &&
				ena_ff[dcs_pkg::INT_FLOW_BIT]) ||
				(flags_ff[dcs_pkg::INT_BUS_ERR_BIT] &&
				ena_ff[dcs_pkg::INT_BUS_ERR_BIT]);
		end
	end

	// ---------------------------------------------------------------
	// Status field and busy
	// ---------------------------------------------------------------
	// Status is history of the last completion only
	// Flags, not this field, give firmware timely events
	// Priority picks a single cause even when several hold
	always_comb begin
		if (err_seen_ff) begin
			status = dcs_pkg::STAT_ERROR;
		end else if (term_seen_ff) begin
			status = dcs_pkg::STAT_TERM;
		end else if (limit_seen_ff) begin
			status = dcs_pkg::STAT_LIMIT;
		end else begin
			status = dcs_pkg::STAT_RUN_OFF;
		end
	end

	// Busy pin follows the state register on the same edge
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_busy <= 1'b0;
		end else begin
			o_busy <= (nxt_state != dcs_pkg::DCS_IDLE);
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Control word as firmware sees it; unused bits read zero
	// Request shows the synced pin while flow control is on, two cycles behind the master
	always_comb begin
		ctl_word = 32'h0000_0000;
		ctl_word[dcs_pkg::CTL_RUN_BIT] = run_ff;
		ctl_word[dcs_pkg::CTL_REQUEST_BIT] = req_live;
		// Done reads zero once the channel is switched off
		ctl_word[dcs_pkg::CTL_DONE_BIT] =
			done_ff && run_ff;
		ctl_word[dcs_pkg::CTL_STATUS_LSB +: 2] = status;
		ctl_word[dcs_pkg::CTL_BUSY_BIT] =
			(state_ff != dcs_pkg::DCS_IDLE);
		ctl_word[dcs_pkg::CTL_DIR_BIT] = dir_ff;
		ctl_word[dcs_pkg::CTL_INC_MEM_BIT] = inc_mem_ff;
		ctl_word[dcs_pkg::CTL_DISABLE_HWFC_BIT] = hwfc_off_ff;
	end

	// Unmapped addresses read zero
	// Decoded from the address beside the read strobe
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (i_addr == ADDR_W'(dcs_pkg::ADDR_CONTROL)) begin
			nxt_rdata = ctl_word;
		end else if (i_addr == ADDR_W'(dcs_pkg::ADDR_INT_FLAGS)) begin
			nxt_rdata[dcs_pkg::INT_WIDTH-1:0] = flags_ff;
		end else if (i_addr == ADDR_W'(dcs_pkg::ADDR_INT_ENABLES)) begin
			nxt_rdata[dcs_pkg::INT_WIDTH-1:0] = ena_ff;
		end
	end

	// Data stands only in the cycle after the read strobe
	// Zero otherwise, so stale data never looks like an answer
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= nxt_rdata;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end
endmodule // dcs_channel

// ---- dcs_fc_master.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Flow-control master model
// ---------------------------------------------------------------
module dcs_fc_master (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_go,
	input wire logic i_hold,
	input wire logic i_term,
	input wire logic i_pkt_start,
	input wire logic i_fc_done,
	output logic o_fc_req,
	output logic o_fc_term
);
	// Request drops once served; hold keeps it up to force overflow
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fc_req <= 1'b0;
		end else if (i_go) begin
			o_fc_req <= 1'b1;
		end else if (!i_hold && (i_pkt_start || i_fc_done)) begin
			o_fc_req <= 1'b0;
		end
	end
	// Terminate follows the bench command
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_fc_term <= 1'b0;
		end else begin
			o_fc_term <= i_term;
		end
	end
endmodule // dcs_fc_master

// ---- dcs_channel_properties.sv ----
`timescale 1ns/1ps
module dcs_channel_chk #(
	parameter int ADDR_W = 8
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic o_fc_done,
	input wire logic o_pkt_start,
	input wire logic o_busy,
	input wire logic o_irq
);
	// ---------------------------------------------------------------
	// Shadows of written bits
	// ---------------------------------------------------------------
	logic run_ff;
	logic [2:0] ena_ff;
	// Mirrors run and enables so outputs can be tied to their cause
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			run_ff <= 1'b0;
			ena_ff <= 3'h0;
		end else if (i_wr && i_addr == dcs_pkg::ADDR_CONTROL) begin
			run_ff <= i_wdata[0];
		end else if (i_wr && i_addr == dcs_pkg::ADDR_INT_ENABLES) begin
			ena_ff <= i_wdata[2:0];
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_rd(logic [7:0] a);
		i_rd && i_addr == a;
	endsequence
	sequence s_off;
		!run_ff [*3];
	endsequence
	a_done_bit: assert property (s_rd(dcs_pkg::ADDR_CONTROL) |=>
		o_rdata[2] == ($past(o_fc_done) && $past(run_ff)))
		else $error("done bit wrong");
	a_busy_bit: assert property (s_rd(dcs_pkg::ADDR_CONTROL) |=>
		o_rdata[5] == $past(o_busy)) else $error("busy bit wrong");
	a_start_from_idle: assert property (o_pkt_start |->
		$rose(o_busy)) else $error("start not from idle");
	a_done_is_busy: assert property (o_fc_done |-> o_busy)
		else $error("done while idle");
	a_off_no_start: assert property (s_off |-> !o_pkt_start)
		else $error("start while off");
	a_off_no_done: assert property (s_off |-> !o_fc_done)
		else $error("done while off");
	a_irq_masked: assert property ((ena_ff == 3'h0) [*2] |-> !o_irq)
		else $error("irq while masked");
	a_irq_cause: assert property (o_irq |-> |$past(ena_ff))
		else $error("irq without enable");
	a_enable_read: assert property (s_rd(dcs_pkg::ADDR_INT_ENABLES) |=>
		o_rdata == {29'h0, $past(ena_ff)}) else $error("enable readback");
	a_rdata_quiet: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data outside slot");
endmodule // dcs_channel_chk
bind dcs_channel dcs_channel_chk #(.ADDR_W(ADDR_W)) u_chk (.i_mclk(i_mclk),
	.i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_rd(i_rd), .o_rdata(o_rdata), .o_fc_done(o_fc_done),
	.o_pkt_start(o_pkt_start), .o_busy(o_busy), .o_irq(o_irq));

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} dcs_row_s;
	logic clk, rst_n, wr, rd, lim, berr, pdone, go, hold, term;
	logic req, trm, fdone, pstart, busy, irq;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	int error_cnt, samples_checked;
	dcs_row_s rows [9] = '{'{0, 8'h14, 0}, '{0, 8'h18, 0}, '{0, 8'h10, 0},
		'{1, 8'h18, 32'hffff_ffff}, '{0, 8'h18, 7}, '{1, 8'h1c, 32'hffff_ffff},
		'{0, 8'h1c, 0}, '{1, 8'h10, 32'h0009_0100}, '{0, 8'h10, 32'h0009_0100}};
	dcs_channel DUT (.i_mclk(clk), .i_reset_n(rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_fc_req(req),
		.i_fc_term(trm), .i_addr_limit(lim), .i_bus_error(berr),
		.i_pkt_done(pdone), .o_fc_done(fdone), .o_pkt_start(pstart),
		.o_busy(busy), .o_irq(irq));
	dcs_fc_master u_master (.i_mclk(clk), .i_reset_n(rst_n), .i_go(go),
		.i_hold(hold), .i_term(term), .i_pkt_start(pstart), .i_fc_done(fdone),
		.o_fc_req(req), .o_fc_term(trm));
	// ---------------------------------------------------------------
	// Bus and compare tasks
	// ---------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] e, m);
		samples_checked++;
		if ((got & m) !== (e & m)) begin
			error_cnt++;
			$display("mismatch at %0t: got %h want %h", $time, got, e);
		end
	endtask
	task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd_t(input logic [7:0] a, input logic [31:0] e, m);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		cmp(rdata, e, m);
	endtask
	// Request a packet and wait a bounded time for busy
	task automatic start_t(input logic h, input logic e);
		@(posedge clk);
		go <= 1'b1;
		hold <= h;
		@(posedge clk);
		go <= 1'b0;
		repeat (20) begin
			@(negedge clk);
			if (busy === 1'b1) break;
		end
		cmp({31'h0, busy}, {31'h0, e}, 1);
	endtask
	// Datapath reports the packet end, limit and error as asked
	task automatic end_t(input logic l, input logic e);
		// A packet takes a few cycles; the stale synced request clears
		repeat (4) @(posedge clk);
		pdone <= 1'b1;
		lim <= l;
		berr <= e;
		@(posedge clk);
		pdone <= 1'b0;
		lim <= 1'b0;
		berr <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task automatic conclude();
		$display("checked %0d, mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Tests take well under 1500 cycles
	initial begin
		#(40 * 5000);
		error_cnt++;
		conclude();
	end
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		{rst_n, wr, rd, lim, berr, pdone, go, hold, term} = '0;
		addr = 8'h0;
		wdata = 32'h0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) wr_t(rows[i].a, rows[i].d);
			else rd_t(rows[i].a, rows[i].d, 32'hffff_ffff);
		end
		$display("register table done");
		wr_t(8'h18, 7);
		wr_t(8'h10, 1);
		start_t(0, 1);
		end_t(1, 0);
		rd_t(8'h14, 4, 7);
		rd_t(8'h10, 32'h2d, 32'h3d);
		cmp(irq, 1, 1);
		wr_t(8'h14, 4);
		rd_t(8'h14, 0, 7);
		wr_t(8'h10, 0);
		rd_t(8'h10, 0, 32'h1d);
		$display("limit test done");
		wr_t(8'h10, 1);
		start_t(1, 1);
		end_t(1, 0);
		hold <= 1'b0;
		rd_t(8'h14, 6, 7);
		wr_t(8'h18, 0);
		rd_t(8'h18, 0, 32'hffff_ffff);
		cmp(irq, 0, 1);
		wr_t(8'h18, 2);
		rd_t(8'h18, 2, 32'hffff_ffff);
		cmp(irq, 1, 1);
		wr_t(8'h14, 7);
		wr_t(8'h18, 4);
		wr_t(8'h10, 0);
		$display("overflow test done");
		wr_t(8'h10, 1);
		start_t(0, 1);
		term <= 1'b1;
		repeat (4) @(posedge clk);
		term <= 1'b0;
		repeat (4) @(posedge clk);
		rd_t(8'h14, 0, 7);
		rd_t(8'h10, 32'h11, 32'h19);
		wr_t(8'h10, 0);
		$display("terminate test done");
		wr_t(8'h10, 1);
		start_t(0, 1);
		end_t(1, 1);
		rd_t(8'h14, 1, 1);
		rd_t(8'h10, 32'h19, 32'h19);
		cmp(irq, 0, 1);
		wr_t(8'h18, 1);
		rd_t(8'h14, 1, 1);
		cmp(irq, 1, 1);
		wr_t(8'h14, 7);
		wr_t(8'h10, 0);
		$display("error test done");
		// Requests are dropped while hardware flow control is off
		wr_t(8'h10, 32'h0008_0001);
		start_t(0, 0);
		rd_t(8'h10, 32'h0008_0001, 32'h0008_0003);
		wr_t(8'h10, 0);
		$display("flow control off test done");
		start_t(0, 0);
		rd_t(8'h10, 2, 3);
		$display("run off test done");
		// Reset with run off and request up clears flags, enables and the synced request
		wr_t(8'h18, 7);
		@(posedge clk);
		berr <= 1'b1;
		@(posedge clk);
		berr <= 1'b0;
		rd_t(8'h14, 1, 7);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_t(8'h14, 0, 7);
		rd_t(8'h18, 0, 32'hffff_ffff);
		rd_t(8'h10, 0, 32'hffff_ffff);
		$display("reset test done");
		conclude();
	end
endmodule // tb
